/* verilog/rims_top.sv */
// Purpose: Loss monitor for two redundant reference inputs and reference selection policy
// Assumes: Edge inputs are single-cycle pulses synchronous to clk
// Notes:   Loop itself is outside; this block only steers selection and holdover
`timescale 1ns/1ps
module rims_top #(
  parameter int NUM_IN = rims_pkg::NUM_IN
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           nrst,
  // Edge streams
  input  wire logic [NUM_IN-1:0]              input_edge,
  input  wire logic                           loss_ref_edge,
  input  wire logic                           loop_tick,
  // Configuration and software clears
  input  wire rims_pkg::rims_cfg_t            cfg,
  input  wire logic [NUM_IN-1:0]              sticky_clear,
  input  wire logic [rims_pkg::TUNE_W-1:0]    tune_in,
  // Status
  output rims_pkg::rims_stat_t                stat,
  output logic                                holdoff_expire,
  output logic [rims_pkg::TUNE_W-1:0]         tune_out
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  if (NUM_IN != 2) begin : g_bad_num
    $error("rims_top serves exactly two inputs");
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Best valid input with nonzero priority; ties go to input 0
  function automatic logic [1:0] pick_best(input logic [1:0] lost,
                                           input logic [1:0][1:0] prio);
    logic ok0;
    logic ok1;
    ok0 = !lost[0] && (prio[0] != rims_pkg::PRIO_NEVER);
    ok1 = !lost[1] && (prio[1] != rims_pkg::PRIO_NEVER);
    if (ok0 && (!ok1 || prio[0] >= prio[1])) begin
      pick_best = 2'h2;
    end else if (ok1) begin
      pick_best = 2'h3;
    end else begin
      pick_best = 2'h0;
    end
  endfunction

  // ****************************************
  // Input monitors
  // ****************************************
  logic [1:0][1:0]                  miss;
  logic [1:0][1:0]                  next_miss;
  logic [1:0][rims_pkg::VCNT_W-1:0] vcnt;
  logic [1:0][rims_pkg::VCNT_W-1:0] next_vcnt;
  logic [1:0]                       live;
  logic [1:0]                       next_live;
  logic [1:0]                       sticky;
  logic [1:0]                       next_sticky;
  logic [1:0]                       armed;
  logic [1:0]                       next_armed;
  logic [rims_pkg::VCNT_W-1:0]      vneed;

  always_comb begin
    // A zero count is taken as one period, so one input edge revalidates
    vneed = (cfg.revalidation_count == rims_pkg::VCNT_ZERO) ? rims_pkg::VCNT_ONE
                                                            : cfg.revalidation_count;
    for (int i = 0; i < 2; i++) begin
      next_miss[i]   = miss[i];
      next_vcnt[i]   = vcnt[i];
      next_live[i]   = live[i];
      next_sticky[i] = sticky[i];
      next_armed[i]  = armed[i];
      if (input_edge[i]) begin
        next_miss[i] = rims_pkg::MISS_ZERO;
      end else if (loss_ref_edge && miss[i] != rims_pkg::MISS_LIMIT) begin
        next_miss[i] = miss[i] + 2'h1;
      end
      if (!live[i] && next_miss[i] == rims_pkg::MISS_LIMIT) begin
        next_live[i] = 1'b1;
        next_vcnt[i] = rims_pkg::VCNT_ZERO;
      end else if (live[i]) begin
        if (input_edge[i]) begin
          if (vcnt[i] + rims_pkg::VCNT_ONE >= vneed) begin
            next_live[i] = 1'b0;
            next_vcnt[i] = rims_pkg::VCNT_ZERO;
          end else begin
            next_vcnt[i] = vcnt[i] + rims_pkg::VCNT_ONE;
          end
        end else if (loss_ref_edge && miss[i] != rims_pkg::MISS_ZERO) begin
          // Two reference edges without input breaks the consecutive run
          next_vcnt[i] = rims_pkg::VCNT_ZERO;
        end
      end
      // Software clear re-arms; an event in the same cycle wins only if the input was already armed
      if (sticky_clear[i]) begin
        next_sticky[i] = 1'b0;
        next_armed[i]  = 1'b1;
      end
      if (!live[i] && next_live[i] && armed[i]) begin
        next_sticky[i] = 1'b1;
        next_armed[i]  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      miss   <= '0;
      vcnt   <= '0;
      live   <= '0;
      sticky <= '0;
      armed  <= '1;
    end else begin
      miss   <= next_miss;
      vcnt   <= next_vcnt;
      live   <= next_live;
      sticky <= next_sticky;
      armed  <= next_armed;
    end
  end

  // ****************************************
  // Hold-off counter
  // ****************************************
  logic                         sel;
  logic                         next_sel;
  logic                         expired;
  logic                         next_expired;
  logic [rims_pkg::PRESC_W-1:0] presc;
  logic [rims_pkg::PRESC_W-1:0] next_presc;
  logic [rims_pkg::HOLD_W-1:0]  hcnt;
  logic [rims_pkg::HOLD_W-1:0]  next_hcnt;
  logic                         next_expire;
  logic                         hold_run;
  logic                         htick;

  always_comb begin
    hold_run     = (cfg.selection_policy == rims_pkg::POL_AUTO_HO) && live[sel] && !expired;
    next_presc   = rims_pkg::PRESC_ZERO;
    next_hcnt    = cfg.holdoff_start_value;
    next_expire  = 1'b0;
    next_expired = expired && live[sel] && (cfg.selection_policy == rims_pkg::POL_AUTO_HO);
    htick        = 1'b0;
    if (hold_run) begin
      next_hcnt = hcnt;
      if (loop_tick) begin
        if (presc + rims_pkg::PRESC_ONE >= cfg.holdoff_prescale) begin
          htick = 1'b1;
        end else begin
          next_presc = presc + rims_pkg::PRESC_ONE;
        end
      end else begin
        next_presc = presc;
      end
      if (htick) begin
        if (hcnt <= rims_pkg::HOLD_ONE) begin
          next_expire  = 1'b1;
          next_expired = 1'b1;
          next_hcnt    = cfg.holdoff_start_value;
        end else begin
          next_hcnt = hcnt - rims_pkg::HOLD_ONE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      presc          <= '0;
      hcnt           <= '0;
      holdoff_expire <= 1'b0;
      expired        <= 1'b0;
    end else begin
      presc          <= next_presc;
      hcnt           <= next_hcnt;
      holdoff_expire <= next_expire;
      expired        <= next_expired;
    end
  end

  // ****************************************
  // Reference selection
  // ****************************************
  logic [1:0]                  best;
  logic [rims_pkg::TUNE_W-1:0] held;
  logic [rims_pkg::TUNE_W-1:0] next_held;

  always_comb begin
    best     = pick_best(live, cfg.priority_lvl);
    next_sel = sel;
    case (cfg.selection_policy)
      rims_pkg::POL_MANUAL,
      rims_pkg::POL_SHORT_HO: begin
        next_sel = cfg.manual_sel;
      end
      rims_pkg::POL_AUTO: begin
        // No valid candidate leaves the selection alone
        if (best[1] && (live[sel] || cfg.priority_lvl[sel] == rims_pkg::PRIO_NEVER)) begin
          next_sel = best[0];
        end else if (best[1] && cfg.revertive_en &&
                     cfg.priority_lvl[best[0]] > cfg.priority_lvl[sel]) begin
          next_sel = best[0];
        end
      end
      rims_pkg::POL_AUTO_HO: begin
        if (best[1] && (next_expire || expired)) begin
          next_sel = best[0];
        end else if (best[1] && !live[sel] &&
                     cfg.priority_lvl[sel] == rims_pkg::PRIO_NEVER) begin
          next_sel = best[0];
        end else if (best[1] && !live[sel] && cfg.revertive_en &&
                     cfg.priority_lvl[best[0]] > cfg.priority_lvl[sel]) begin
          next_sel = best[0];
        end
      end
      default: begin
        next_sel = sel;
      end
    endcase
    // Holdover freezes the control word at its last tracked value
    next_held = stat.holdover ? held : tune_in;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel  <= 1'b0;
      held <= rims_pkg::TUNE_RESET;
    end else begin
      sel  <= next_sel;
      held <= next_held;
    end
  end

  // ****************************************
  // Status
  // ****************************************
  always_comb begin
    stat.input_loss_live_flag   = live;
    stat.input_loss_sticky_flag = sticky;
    stat.loss_of_signal_n       = ~|(live & ~cfg.input_disable_bit);
    stat.selected               = sel;
    stat.holdover               = live[sel] &&
                                  (cfg.selection_policy == rims_pkg::POL_SHORT_HO ||
                                   cfg.selection_policy == rims_pkg::POL_AUTO_HO);
    stat.locked                 = !live[sel];
    tune_out                    = held;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_loss_three_miss: assert property (
    (!live[0] && miss[0] == 2'h2 && loss_ref_edge && !input_edge[0]) |=> live[0])
    else $error("input 0 not lost after third missed edge");
  a_sticky_holds: assert property (
    (sticky[0] && !sticky_clear[0]) |=> sticky[0])
    else $error("sticky flag dropped without clear");
  a_rearm_gate: assert property (
    $rose(sticky[1]) |-> $past(armed[1]))
    else $error("loss event raised while not re-armed");
  a_gpio_combine: assert property (
    (live[0] && !cfg.input_disable_bit[0]) |-> !stat.loss_of_signal_n)
    else $error("combined loss pin high with enabled input lost");
  a_manual_follow: assert property (
    (cfg.selection_policy == rims_pkg::POL_MANUAL) [*2] |-> sel == $past(cfg.manual_sel))
    else $error("manual selection not followed");
  a_short_holdover: assert property (
    (cfg.selection_policy == rims_pkg::POL_SHORT_HO && live[sel]) |-> stat.holdover)
    else $error("short holdover not entered");
  a_auto_failover: assert property (
    (cfg.selection_policy == rims_pkg::POL_AUTO && live[sel] && !live[!sel] &&
     cfg.priority_lvl[!sel] != 2'h0) |=> sel != $past(sel))
    else $error("automatic failover missing");
  a_prio_zero_never: assert property (
    (cfg.selection_policy[0] && $changed(sel) && $stable(cfg)) |-> cfg.priority_lvl[sel] != 2'h0)
    else $error("priority zero input selected");
  a_holdoff_gated: assert property (
    !(cfg.selection_policy == rims_pkg::POL_AUTO_HO && live[sel]) |=> presc == 18'h00000)
    else $error("hold-off prescaler ran while disabled");
  a_holdoff_wait: assert property (
    (cfg.selection_policy == rims_pkg::POL_AUTO_HO && live[sel] && !expired && !next_expire &&
     $stable(cfg) && cfg.priority_lvl[sel] != 2'h0 && !(cfg.revertive_en)) |=> $stable(sel))
    else $error("switch before hold-off expiry");

  c_failover: cover property (cfg.selection_policy == rims_pkg::POL_AUTO && $changed(sel));
  c_expire: cover property (holdoff_expire);
  c_revalid: cover property ($fell(live[0]));
  c_rearm: cover property (sticky_clear[0] ##[1:50] $rose(sticky[0]));
endmodule // rims_top

/* verilog/rims_pkg.sv */
// Purpose: Shared constants and carriers for the redundant input monitor and selector
// Assumes: Two reference inputs, events arrive as one-cycle pulses on clk
// Notes:   Policy codes and field widths are fixed by the control interface
package rims_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_IN    = 2;
  localparam int VCNT_W    = 8;
  localparam int HOLD_W    = 8;
  localparam int PRESC_W   = 18;
  localparam int PRIO_W    = 2;
  localparam int TUNE_W    = 24;
  // ****************************************
  // Loss detection and reset values
  // ****************************************
  localparam logic [1:0]         MISS_LIMIT   = 2'h3;
  localparam logic [1:0]         MISS_ZERO    = 2'h0;
  localparam logic [VCNT_W-1:0]  VCNT_ZERO    = 8'h00;
  localparam logic [VCNT_W-1:0]  VCNT_ONE     = 8'h01;
  localparam logic [HOLD_W-1:0]  HOLD_ZERO    = 8'h00;
  localparam logic [HOLD_W-1:0]  HOLD_ONE     = 8'h01;
  localparam logic [PRESC_W-1:0] PRESC_ZERO   = 18'h00000;
  localparam logic [PRESC_W-1:0] PRESC_ONE    = 18'h00001;
  localparam logic [PRIO_W-1:0]  PRIO_NEVER   = 2'h0;
  localparam logic [TUNE_W-1:0]  TUNE_RESET   = 24'h000000;
  // ****************************************
  // Selection policies
  // ****************************************
  localparam logic [1:0] POL_MANUAL   = 2'h0;
  localparam logic [1:0] POL_AUTO     = 2'h1;
  localparam logic [1:0] POL_SHORT_HO = 2'h2;
  localparam logic [1:0] POL_AUTO_HO  = 2'h3;

  typedef struct packed {
    logic [1:0]                    selection_policy;
    logic                          manual_sel;
    logic [NUM_IN-1:0]             input_disable_bit;
    logic [NUM_IN-1:0][PRIO_W-1:0] priority_lvl;
    logic                          revertive_en;
    logic [VCNT_W-1:0]             revalidation_count;
    logic [HOLD_W-1:0]             holdoff_start_value;
    logic [PRESC_W-1:0]            holdoff_prescale;
  } rims_cfg_t;

  typedef struct packed {
    logic [NUM_IN-1:0] input_loss_live_flag;
    logic [NUM_IN-1:0] input_loss_sticky_flag;
    logic              loss_of_signal_n;
    logic              selected;
    logic              holdover;
    logic              locked;
  } rims_stat_t;
endpackage

/* dv/rims_ref_src.sv */
// Purpose: Far-side model of the two reference clocks, loss-reference divider and loop
// Assumes: Divider rate matches the pre-divided input rate, edges as one-cycle pulses
// Notes:   A stopped input shows no edges at all, as a static clock would
`timescale 1ns/1ps
module rims_ref_src (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control from the bench
  input  wire logic [1:0] run,
  // Edge streams
  output logic      [1:0] input_edge,
  output logic            loss_ref_edge,
  output logic            loop_tick
);
  logic [1:0] phase;
  logic [1:0] tick_phase;

  // Powered-up divider, rate equal to the inputs, inputs far below the monitor limit
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase         <= 2'h0;
      tick_phase    <= 2'h0;
      input_edge    <= 2'h0;
      loss_ref_edge <= 1'b0;
      loop_tick     <= 1'b0;
    end else begin
      phase         <= #1 phase + 2'h1;
      tick_phase    <= #1 (tick_phase == 2'h2) ? 2'h0 : tick_phase + 2'h1;
      loss_ref_edge <= #1 (phase == 2'h3);
      input_edge    <= #1 run & {2{phase == 2'h3}};
      loop_tick     <= #1 (tick_phase == 2'h2);
    end
  end
endmodule // rims_ref_src

/* dv/redundant_input_monitor_selector_tb.sv */
// Purpose: Self-checking bench for loss monitoring and reference selection
// Assumes: Partner model supplies all edge streams
// Notes:   Random revalidation count, hold-off start value and loop word
`timescale 1ns/1ps
module redundant_input_monitor_selector_tb;
  logic                clk = 1'b0;
  logic                nrst = 1'b0;
  logic [1:0]          run = 2'h3;
  logic [1:0]          input_edge;
  logic                loss_ref_edge;
  logic                loop_tick;
  rims_pkg::rims_cfg_t cfg = '0;
  logic [1:0]          sticky_clear = 2'h0;
  logic [23:0]         tune_in = 24'h000000;
  rims_pkg::rims_stat_t stat;
  logic                holdoff_expire;
  logic [23:0]         tune_out;
  int                  mismatches = 0;
  int                  compares = 0;
  int                  n;
  int                  seed_dummy;
  logic [23:0]         frozen;

  always #5 clk = ~clk;

  rims_ref_src SRC (.clk(clk), .nrst(nrst), .run(run), .input_edge(input_edge),
    .loss_ref_edge(loss_ref_edge), .loop_tick(loop_tick));
  rims_top DUT (.clk(clk), .nrst(nrst), .input_edge(input_edge), .loss_ref_edge(loss_ref_edge),
    .loop_tick(loop_tick), .cfg(cfg), .sticky_clear(sticky_clear), .tune_in(tune_in),
    .stat(stat), .holdoff_expire(holdoff_expire), .tune_out(tune_out));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_bit(string name, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_word(string name, logic [23:0] exp, logic [23:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Stops an input, counts divider edges with no input edge until the live flag shows
  task automatic lose(int i, output int cnt);
    int k;
    cnt = 0;
    k = 0;
    @(posedge clk);
    #1;
    run[i] = 1'b0;
    @(negedge clk);
    while (stat.input_loss_live_flag[i] !== 1'b1 && k < 60) begin
      // A divider edge paired with an input edge in the same cycle is not a missing edge
      if (loss_ref_edge === 1'b1 && input_edge[i] !== 1'b1) cnt++;
      @(negedge clk);
      k++;
    end
  endtask

  // Restarts an input, counts its edges until the live flag drops
  task automatic restore(int i, output int cnt);
    int k;
    cnt = 0;
    k = 0;
    @(posedge clk);
    #1;
    run[i] = 1'b1;
    @(negedge clk);
    while (stat.input_loss_live_flag[i] !== 1'b0 && k < 60) begin
      if (input_edge[i] === 1'b1) cnt++;
      @(negedge clk);
      k++;
    end
  endtask

  task automatic clear_sticky();
    cyc(1);
    sticky_clear = 2'h3;
    cyc(1);
    sticky_clear = 2'h0;
    cyc(1);
  endtask

  function automatic logic [23:0] eff(logic [7:0] v);
    return (v == 8'h00) ? 24'h000001 : {16'h0000, v};
  endfunction

  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed_dummy = $urandom(32'hf4178025);
    cfg.priority_lvl[0] = 2'h2;
    cfg.priority_lvl[1] = 2'h1;
    cfg.revalidation_count = 8'($urandom_range(1, 4));
    cfg.holdoff_start_value = 8'($urandom_range(1, 5));
    cfg.holdoff_prescale = rims_pkg::PRESC_ONE;
    cyc(3);
    chk_word("live", 24'h0, {22'h0, stat.input_loss_live_flag});
    chk_word("sticky", 24'h0, {22'h0, stat.input_loss_sticky_flag});
    chk_bit("los_n", 1'b1, stat.loss_of_signal_n);
    chk_bit("locked", 1'b1, stat.locked);
    nrst = 1'b1;
    cyc(12);
    cfg.manual_sel = 1'b1;
    cyc(2);
    chk_bit("manual sel", 1'b1, stat.selected);
    cfg.manual_sel = 1'b0;
    cyc(2);
    lose(0, n);
    chk_word("missing edges", 24'd3, 24'(n));
    chk_bit("sticky0", 1'b1, stat.input_loss_sticky_flag[0]);
    chk_bit("los_n lost", 1'b0, stat.loss_of_signal_n);
    chk_bit("unlocked", 1'b0, stat.locked);
    cyc(2);
    chk_bit("manual kept", 1'b0, stat.selected);
    cfg.input_disable_bit = 2'h1;
    cyc(1);
    chk_bit("los_n disabled", 1'b1, stat.loss_of_signal_n);
    cfg.input_disable_bit = 2'h0;
    restore(0, n);
    chk_word("reval periods", eff(cfg.revalidation_count), 24'(n));
    chk_bit("sticky held", 1'b1, stat.input_loss_sticky_flag[0]);
    chk_bit("relocked", 1'b1, stat.locked);
    clear_sticky();
    chk_bit("sticky cleared", 1'b0, stat.input_loss_sticky_flag[0]);
    cfg.selection_policy = rims_pkg::POL_SHORT_HO;
    tune_in = 24'($urandom);
    cyc(2);
    lose(0, n);
    cyc(1);
    frozen = tune_in;
    chk_bit("short holdover", 1'b1, stat.holdover);
    tune_in = ~tune_in;
    cyc(3);
    chk_word("frozen word", frozen, tune_out);
    chk_bit("short sel", 1'b0, stat.selected);
    restore(0, n);
    cyc(2);
    chk_bit("holdover left", 1'b0, stat.holdover);
    chk_word("tracking word", tune_in, tune_out);
    clear_sticky();
    cfg.selection_policy = rims_pkg::POL_AUTO;
    lose(0, n);
    cyc(2);
    chk_bit("failover", 1'b1, stat.selected);
    lose(1, n);
    cyc(2);
    chk_bit("none valid sel", 1'b1, stat.selected);
    chk_bit("none valid ho", 1'b0, stat.holdover);
    restore(0, n);
    cyc(2);
    chk_bit("revalid target", 1'b0, stat.selected);
    restore(1, n);
    clear_sticky();
    cfg.priority_lvl[1] = 2'h0;
    lose(0, n);
    cyc(2);
    chk_bit("prio zero", 1'b0, stat.selected);
    restore(0, n);
    clear_sticky();
    cfg.priority_lvl[1] = 2'h1;
    cfg.priority_lvl[0] = 2'h0;
    cyc(3);
    chk_bit("prio change", 1'b1, stat.selected);
    cfg.priority_lvl[0] = 2'h2;
    cyc(3);
    chk_bit("non revertive", 1'b1, stat.selected);
    lose(0, n);
    cyc(1);
    chk_bit("lost other kept", 1'b1, stat.selected);
    cfg.revertive_en = 1'b1;
    restore(0, n);
    cyc(2);
    chk_bit("revertive", 1'b0, stat.selected);
    cfg.revertive_en = 1'b0;
    clear_sticky();
    cfg.selection_policy = rims_pkg::POL_AUTO_HO;
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (holdoff_expire === 1'b1) n++;
    end
    chk_word("idle expiry", 24'h0, 24'(n));
    lose(0, n);
    chk_bit("auto holdover", 1'b1, stat.holdover);
    n = 0;
    while (holdoff_expire !== 1'b1 && n < 200) begin
      if (loop_tick === 1'b1) n++;
      chk_bit("deferred sel", 1'b0, stat.selected);
      @(negedge clk);
    end
    chk_word("holdoff ticks", eff(cfg.holdoff_start_value), 24'(n));
    cyc(1);
    chk_bit("expiry switch", 1'b1, stat.selected);
    chk_bit("holdover off", 1'b0, stat.holdover);
    // Corner cases: zero revalidation count, zero start value, prescale of two
    cfg.revalidation_count = 8'h00;
    restore(0, n);
    chk_word("reval zero", eff(8'h00), 24'(n));
    cyc(1);
    cfg.holdoff_prescale = 18'h00002;
    cfg.holdoff_start_value = 8'h00;
    lose(0, n);
    cyc(1);
    chk_bit("other lost kept", 1'b1, stat.selected);
    lose(1, n);
    n = 0;
    while (holdoff_expire !== 1'b1 && n < 200) begin
      if (loop_tick === 1'b1) n++;
      chk_bit("deferred sel 1", 1'b1, stat.selected);
      @(negedge clk);
    end
    chk_word("prescaled ticks", eff(8'h00) + eff(8'h00), 24'(n));
    cyc(2);
    chk_bit("none valid stay", 1'b1, stat.selected);
    chk_bit("none valid hold", 1'b1, stat.holdover);
    restore(0, n);
    cyc(2);
    chk_bit("first revalid", 1'b0, stat.selected);
    chk_bit("hold left", 1'b0, stat.holdover);
    restore(1, n);
    clear_sticky();
    complete_run();
  end
endmodule // redundant_input_monitor_selector_tb
